// File: logic/ptp_pkg.sv
// constants for the protection and trace provisioning register bank
// assumes a 32-bit register port with 8-bit byte addresses
package ptp_pkg;
  localparam int DW = 32;
  localparam int AW = 8;
  // register byte addresses
  localparam logic [7:0] SNC_CFG    = 8'h00;
  localparam logic [7:0] SNC_MEMB   = 8'h04;
  localparam logic [7:0] TRL_CFG    = 8'h08;
  localparam logic [7:0] TRL_MEMB   = 8'h0c;
  localparam logic [7:0] CMD_REG    = 8'h10;
  localparam logic [7:0] TRACE_CTRL = 8'h14;
  localparam logic [7:0] STATUS_REG = 8'h18;
  localparam logic [7:0] IRQ_STAT   = 8'h1c;
  localparam logic [7:0] IRQ_MASK   = 8'h20;
  localparam logic [7:0] TX_BASE    = 8'h40;
  localparam logic [7:0] EXP_BASE   = 8'h50;
  localparam logic [7:0] ACC_BASE   = 8'h60;
  // configuration register fields
  localparam int CFG_REV_BIT  = 0;
  localparam int CFG_KIND_LSB = 1;
  localparam int CFG_WTR_LSB  = 4;
  localparam int CFG_HO_LSB   = 8;
  localparam int CFG_DEL_BIT  = 31;
  localparam int MEMB_ROLE_LSB = 8;
  // command register fields
  localparam int CMD_LMS_LSB  = 0;
  localparam int CMD_RING_LSB = 4;
  localparam int CMD_SNC_LSB  = 8;
  localparam int CMD_TRL_LSB  = 12;
  // trace control and status fields
  localparam int TC_MODE_BIT  = 0;
  localparam int TC_OFF_BIT   = 1;
  localparam int ST_KIND_BIT  = 0;
  localparam int ST_ACCREP_BIT = 1;
  localparam int ST_EXPREP_BIT = 2;
  localparam int ST_DEF_BIT   = 3;
  // switch event bits, same layout in status and mask
  localparam int N_EV   = 4;
  localparam int EV_SNC = 0;
  localparam int EV_TRL = 1;
  localparam int EV_LMS = 2;
  localparam int EV_RING = 3;
  // value ranges and defaults
  localparam logic       OPER_NONREV  = 1'h0;
  localparam logic [3:0] WTR_MAX_MIN  = 4'hc;
  localparam logic [3:0] WTR_DEF_MIN  = 4'h5;
  localparam int         HO_STEP_MS   = 100;
  localparam logic [6:0] HO_MAX_STEPS = 7'h64;
  localparam logic [6:0] HO_DEF_STEPS = 7'h00;
  localparam logic       TRACE_MODE1  = 1'h0;
  localparam logic       TIM_OFF_DEF  = 1'h0;
  localparam int         TRACE_W      = 128;
  localparam int         TRACE_WORDS  = 4;
  // subnetwork protection kinds, zero means not yet set
  localparam logic [1:0] KIND_UNSET   = 2'h0;
  localparam logic [1:0] KIND_INHER   = 2'h1;
  localparam logic [1:0] KIND_NONINTR = 2'h2;
  // linear external commands (3 bits)
  localparam logic [2:0] LC_NONE       = 3'h0;
  localparam logic [2:0] LC_CANCEL     = 3'h1;
  localparam logic [2:0] LC_BARRING    = 3'h2;
  localparam logic [2:0] LC_FORCED     = 3'h3;
  localparam logic [2:0] LC_MANUAL     = 3'h4;
  localparam logic [2:0] LC_TRIAL      = 3'h5;
  localparam logic [2:0] LC_NORM_BAR   = 3'h6;
  localparam logic [2:0] LC_CANCEL_NB  = 3'h7;
  // shared ring external commands (4 bits)
  localparam logic [3:0] RC_NONE        = 4'h0;
  localparam logic [3:0] RC_CANCEL      = 4'h1;
  localparam logic [3:0] RC_SPAN_SB_BAR = 4'h2;
  localparam logic [3:0] RC_ALL_SB_BAR  = 4'hb;
endpackage : ptp_pkg

// File: logic/ptp_top.sv
// provisioning and control register bank for subnetwork and trail
// protection, external switch commands and trace identifier handling
// assumes a same-clock manager port and same-clock adaptation logic
`timescale 1ns/1ns
module ptp_top
  import ptp_pkg::*;
#(
  parameter int N_MEMB = 8
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic [ptp_pkg::AW-1:0] addr,
  input  wire logic [ptp_pkg::DW-1:0] wdata,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  output logic [ptp_pkg::DW-1:0]     rdata,
  input  wire logic [ptp_pkg::N_EV-1:0] switch_event_report,
  input  wire logic [ptp_pkg::TRACE_W-1:0] accepted_trace_value,
  output logic                       snc_operation_mode_sel,
  output logic [1:0]                 snc_subnet_prot_kind,
  output logic [3:0]                 snc_wait_restore_time,
  output logic [6:0]                 snc_hold_off_delay,
  output logic [N_MEMB-1:0]          snc_members,
  output logic [N_MEMB-1:0]          snc_roles,
  output logic                       trl_operation_mode_sel,
  output logic [3:0]                 trl_wait_restore_time,
  output logic [6:0]                 trl_hold_off_delay,
  output logic [N_MEMB-1:0]          trl_members,
  output logic [N_MEMB-1:0]          trl_roles,
  output logic [2:0]                 lms_external_switch_cmd,
  output logic [3:0]                 ring_external_switch_cmd,
  output logic [2:0]                 snc_external_switch_cmd,
  output logic [2:0]                 trl_external_switch_cmd,
  output logic [ptp_pkg::TRACE_W-1:0] sent_trace_value,
  output logic [ptp_pkg::TRACE_W-1:0] expected_trace_value,
  output logic                       expected_trace_mode,
  output logic                       mismatch_detect_off,
  output logic                       trace_mismatch_defect,
  output logic                       irq
);
  import ptp_pkg::*;

  // all sixteen bytes equal to the first one
  function automatic logic all_same(input logic [TRACE_W-1:0] v);
    logic r;
    r = 1'b1;
    for (int i = 1; i < TRACE_W / 8; i++) begin
      if (v[i*8 +: 8] != v[7:0]) r = 1'b0;
    end
    return r;
  endfunction : all_same

  // linear command code check; normal barring codes only for the section
  function automatic logic lin_ok(input logic [2:0] c, input logic sect);
    return (c >= LC_CANCEL && c <= LC_TRIAL) || (sect && c != LC_NONE);
  endfunction : lin_ok

  function automatic logic wtr_ok(input logic [DW-1:0] d);
    return d[CFG_WTR_LSB +: 4] <= WTR_MAX_MIN;
  endfunction : wtr_ok

  function automatic logic ho_ok(input logic [DW-1:0] d);
    return d[CFG_HO_LSB +: 7] <= HO_MAX_STEPS;
  endfunction : ho_ok

  logic                wr_snc_cfg, wr_snc_memb, wr_trl_cfg, wr_trl_memb;
  logic                snc_cfg_ok, trl_cfg_ok;
  logic [1:0]          w_kind;
  logic [2:0]          w_lms, w_snc, w_trl;
  logic [3:0]          w_ring;
  logic                rd_irq;
  logic [N_EV-1:0]     stat_ff, mask_ff;
  logic [TRACE_W-1:0]  acc_ff;
  logic [DW-1:0]       rdata_ff;

  assign wr_snc_cfg  = wr_stb && addr == SNC_CFG;
  assign wr_snc_memb = wr_stb && addr == SNC_MEMB;
  assign wr_trl_cfg  = wr_stb && addr == TRL_CFG;
  assign wr_trl_memb = wr_stb && addr == TRL_MEMB;
  assign w_kind      = wdata[CFG_KIND_LSB +: 2];
  // write acceptance checks
  assign snc_cfg_ok  = (w_kind == KIND_INHER || w_kind == KIND_NONINTR) &&
                       wtr_ok(wdata) && ho_ok(wdata);
  assign trl_cfg_ok  = wtr_ok(wdata) && ho_ok(wdata);

  // subnetwork group settings
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snc_operation_mode_sel <= OPER_NONREV;
      snc_subnet_prot_kind   <= KIND_UNSET;
      snc_wait_restore_time  <= WTR_DEF_MIN;
      snc_hold_off_delay     <= HO_DEF_STEPS;
    end else if (wr_snc_cfg && wdata[CFG_DEL_BIT]) begin
      snc_operation_mode_sel <= OPER_NONREV;
      snc_subnet_prot_kind   <= KIND_UNSET;
      snc_wait_restore_time  <= WTR_DEF_MIN;
      snc_hold_off_delay     <= HO_DEF_STEPS;
    end else if (wr_snc_cfg && snc_cfg_ok) begin
      snc_operation_mode_sel <= wdata[CFG_REV_BIT];
      snc_subnet_prot_kind   <= w_kind;
      snc_wait_restore_time  <= wdata[CFG_WTR_LSB +: 4];
      snc_hold_off_delay     <= wdata[CFG_HO_LSB +: 7];
    end
  end

  // subnetwork group members and roles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snc_members <= '0;
      snc_roles   <= '0;
    end else if (wr_snc_cfg && wdata[CFG_DEL_BIT]) begin
      snc_members <= '0;
      snc_roles   <= '0;
    end else if (wr_snc_memb) begin
      snc_members <= wdata[N_MEMB-1:0];
      snc_roles   <= wdata[MEMB_ROLE_LSB +: N_MEMB];
    end
  end

  // trail group settings, members and roles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trl_operation_mode_sel <= OPER_NONREV;
      trl_wait_restore_time  <= WTR_DEF_MIN;
      trl_hold_off_delay     <= HO_DEF_STEPS;
      trl_members            <= '0;
      trl_roles              <= '0;
    end else if (wr_trl_cfg && wdata[CFG_DEL_BIT]) begin
      trl_operation_mode_sel <= OPER_NONREV;
      trl_wait_restore_time  <= WTR_DEF_MIN;
      trl_hold_off_delay     <= HO_DEF_STEPS;
      trl_members            <= '0;
      trl_roles              <= '0;
    end else if (wr_trl_cfg && trl_cfg_ok) begin
      trl_operation_mode_sel <= wdata[CFG_REV_BIT];
      trl_wait_restore_time  <= wdata[CFG_WTR_LSB +: 4];
      trl_hold_off_delay     <= wdata[CFG_HO_LSB +: 7];
    end else if (wr_trl_memb) begin
      trl_members <= wdata[N_MEMB-1:0];
      trl_roles   <= wdata[MEMB_ROLE_LSB +: N_MEMB];
    end
  end

  assign w_lms  = wdata[CMD_LMS_LSB +: 3];
  assign w_ring = wdata[CMD_RING_LSB +: 4];
  assign w_snc  = wdata[CMD_SNC_LSB +: 3];
  assign w_trl  = wdata[CMD_TRL_LSB +: 3];

  // external commands; each field kept if its code is not legal
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lms_external_switch_cmd  <= LC_NONE;
      ring_external_switch_cmd <= RC_NONE;
      snc_external_switch_cmd  <= LC_NONE;
      trl_external_switch_cmd  <= LC_NONE;
    end else if (wr_stb && addr == CMD_REG) begin
      if (lin_ok(w_lms, 1'b1)) lms_external_switch_cmd <= w_lms;
      if (w_ring >= RC_CANCEL && w_ring <= RC_ALL_SB_BAR) begin
        ring_external_switch_cmd <= w_ring;
      end
      if (lin_ok(w_snc, 1'b0)) snc_external_switch_cmd <= w_snc;
      if (lin_ok(w_trl, 1'b0)) trl_external_switch_cmd <= w_trl;
    end
  end

  // trace provisioning: mode, detection control, sent and expected words
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      expected_trace_mode  <= TRACE_MODE1;
      mismatch_detect_off  <= TIM_OFF_DEF;
      sent_trace_value     <= '0;
      expected_trace_value <= '0;
    end else if (wr_stb) begin
      if (addr == TRACE_CTRL) begin
        expected_trace_mode <= wdata[TC_MODE_BIT];
        mismatch_detect_off <= wdata[TC_OFF_BIT];
      end else if (addr[7:4] == TX_BASE[7:4]) begin
        sent_trace_value[addr[3:2]*DW +: DW] <= wdata;
      end else if (addr[7:4] == EXP_BASE[7:4]) begin
        expected_trace_value[addr[3:2]*DW +: DW] <= wdata;
      end
    end
  end

  // snapshot of the accepted trace on request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= '0;
    end else if (rd_stb && addr == ACC_BASE) begin
      acc_ff <= accepted_trace_value;
    end
  end

  // mismatch defect, held off by the disable bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trace_mismatch_defect <= 1'b0;
    end else begin
      trace_mismatch_defect <= !mismatch_detect_off &&
        (accepted_trace_value != expected_trace_value);
    end
  end

  // sticky switch events; set beats the clear of a status read
  assign rd_irq = rd_stb && addr == IRQ_STAT;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= (rd_irq ? '0 : stat_ff) | switch_event_report;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= '0;
    end else if (wr_stb && addr == IRQ_MASK) begin
      mask_ff <= wdata[N_EV-1:0];
    end
  end

  assign irq = |(stat_ff & mask_ff);

  // read data, valid the cycle after the read strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (rd_stb) begin
      rdata_ff <= '0;
      if (addr == SNC_CFG) begin
        rdata_ff[CFG_REV_BIT]       <= snc_operation_mode_sel;
        rdata_ff[CFG_KIND_LSB +: 2] <= snc_subnet_prot_kind;
        rdata_ff[CFG_WTR_LSB +: 4]  <= snc_wait_restore_time;
        rdata_ff[CFG_HO_LSB +: 7]   <= snc_hold_off_delay;
      end else if (addr == SNC_MEMB) begin
        rdata_ff[N_MEMB-1:0]              <= snc_members;
        rdata_ff[MEMB_ROLE_LSB +: N_MEMB] <= snc_roles;
      end else if (addr == TRL_CFG) begin
        rdata_ff[CFG_REV_BIT]      <= trl_operation_mode_sel;
        rdata_ff[CFG_WTR_LSB +: 4] <= trl_wait_restore_time;
        rdata_ff[CFG_HO_LSB +: 7]  <= trl_hold_off_delay;
      end else if (addr == TRL_MEMB) begin
        rdata_ff[N_MEMB-1:0]              <= trl_members;
        rdata_ff[MEMB_ROLE_LSB +: N_MEMB] <= trl_roles;
      end else if (addr == CMD_REG) begin
        rdata_ff[CMD_LMS_LSB +: 3]  <= lms_external_switch_cmd;
        rdata_ff[CMD_RING_LSB +: 4] <= ring_external_switch_cmd;
        rdata_ff[CMD_SNC_LSB +: 3]  <= snc_external_switch_cmd;
        rdata_ff[CMD_TRL_LSB +: 3]  <= trl_external_switch_cmd;
      end else if (addr == TRACE_CTRL) begin
        rdata_ff[TC_MODE_BIT] <= expected_trace_mode;
        rdata_ff[TC_OFF_BIT]  <= mismatch_detect_off;
      end else if (addr == STATUS_REG) begin
        rdata_ff[ST_KIND_BIT]   <= snc_subnet_prot_kind != KIND_UNSET;
        rdata_ff[ST_ACCREP_BIT] <= all_same(acc_ff);
        rdata_ff[ST_EXPREP_BIT] <= all_same(expected_trace_value);
        rdata_ff[ST_DEF_BIT]    <= trace_mismatch_defect;
      end else if (addr == IRQ_STAT) begin
        rdata_ff[N_EV-1:0] <= stat_ff;
      end else if (addr == IRQ_MASK) begin
        rdata_ff[N_EV-1:0] <= mask_ff;
      end else if (addr == ACC_BASE) begin
        rdata_ff <= accepted_trace_value[DW-1:0];
      end else if (addr[7:4] == ACC_BASE[7:4]) begin
        rdata_ff <= acc_ff[addr[3:2]*DW +: DW];
      end else if (addr[7:4] == TX_BASE[7:4]) begin
        rdata_ff <= sent_trace_value[addr[3:2]*DW +: DW];
      end else if (addr[7:4] == EXP_BASE[7:4]) begin
        rdata_ff <= expected_trace_value[addr[3:2]*DW +: DW];
      end
    end
  end

  assign rdata = rdata_ff;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence bad_wtr_write;
    wr_stb && addr == SNC_CFG && !wdata[CFG_DEL_BIT] &&
    wdata[CFG_WTR_LSB +: 4] > WTR_MAX_MIN;
  endsequence

  sequence acc_request;
    rd_stb && addr == ACC_BASE;
  endsequence

  snc_reject_a: assert property (bad_wtr_write |=>
    $stable(snc_wait_restore_time) && $stable(snc_subnet_prot_kind))
    else $error("out-of-range write changed subnet settings");
  wtr_range_a: assert property (
    snc_wait_restore_time <= WTR_MAX_MIN &&
    trl_wait_restore_time <= WTR_MAX_MIN)
    else $error("wait-to-restore above range");
  ho_range_a: assert property (
    snc_hold_off_delay <= HO_MAX_STEPS && trl_hold_off_delay <= HO_MAX_STEPS)
    else $error("hold-off above range");
  kind_legal_a: assert property (
    snc_subnet_prot_kind <= KIND_NONINTR)
    else $error("illegal subnet protection kind");
  group_remove_a: assert property (
    wr_stb && addr == TRL_CFG && wdata[CFG_DEL_BIT] |=>
    trl_members == '0 && trl_wait_restore_time == WTR_DEF_MIN &&
    trl_operation_mode_sel == OPER_NONREV)
    else $error("trail group not removed");
  cmd_legal_a: assert property (
    snc_external_switch_cmd <= LC_TRIAL && trl_external_switch_cmd <= LC_TRIAL)
    else $error("illegal subnet or trail command");
  ring_legal_a: assert property (
    ring_external_switch_cmd <= RC_ALL_SB_BAR)
    else $error("illegal ring command");
  event_sticky_a: assert property (
    switch_event_report[EV_SNC] |=> stat_ff[EV_SNC] [*1] ##0
    (rd_irq || $past(rd_irq) || stat_ff[EV_SNC]))
    else $error("switch event lost");
  acc_snap_a: assert property (acc_request |=>
    acc_ff == $past(accepted_trace_value) &&
    rdata == $past(accepted_trace_value[DW-1:0]))
    else $error("accepted trace not returned");
  tim_off_a: assert property (
    mismatch_detect_off ##1 mismatch_detect_off |-> !trace_mismatch_defect)
    else $error("mismatch defect while detection disabled");

  sequence bad_ho_trl_write;
    wr_stb && addr == TRL_CFG && !wdata[CFG_DEL_BIT] &&
    wdata[CFG_HO_LSB +: 7] > HO_MAX_STEPS;
  endsequence

  sequence snc_remove;
    wr_stb && addr == SNC_CFG && wdata[CFG_DEL_BIT];
  endsequence

  sequence unset_kind_write;
    wr_stb && addr == SNC_CFG && !wdata[CFG_DEL_BIT] &&
    wdata[CFG_KIND_LSB +: 2] == KIND_UNSET;
  endsequence

  sequence status_read_idle;
    rd_stb && addr == IRQ_STAT && switch_event_report == '0;
  endsequence

  // refused writes, group removal, read-clear and trace control
  trl_reject_a: assert property (bad_ho_trl_write |=>
    $stable(trl_hold_off_delay) && $stable(trl_wait_restore_time) &&
    $stable(trl_operation_mode_sel))
    else $error("out-of-range write changed trail settings");
  snc_remove_a: assert property (snc_remove |=>
    snc_members == '0 && snc_roles == '0 &&
    snc_subnet_prot_kind == KIND_UNSET &&
    snc_wait_restore_time == WTR_DEF_MIN)
    else $error("subnet group not removed");
  kind_unset_a: assert property (unset_kind_write |=>
    $stable(snc_subnet_prot_kind) && $stable(snc_operation_mode_sel))
    else $error("subnet write without kind accepted");
  status_clear_a: assert property (status_read_idle |=>
    stat_ff == '0 && !irq)
    else $error("status read did not clear events");
  lms_none_a: assert property (
    wr_stb && addr == CMD_REG && wdata[CMD_LMS_LSB +: 3] == LC_NONE |=>
    $stable(lms_external_switch_cmd))
    else $error("no-command code replaced a section command");
  trace_mode_a: assert property (
    wr_stb && addr == TRACE_CTRL |=>
    expected_trace_mode == $past(wdata[TC_MODE_BIT]) &&
    mismatch_detect_off == $past(wdata[TC_OFF_BIT]))
    else $error("trace control write not applied");
endmodule : ptp_top

// File: dv/ptp_adapt_model.sv
// adaptation side model: switch event pulses and accepted trace
// assumes the bank's clock and reset; the bench calls its tasks
`timescale 1ns/1ns
module ptp_adapt_model
  import ptp_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  output logic [ptp_pkg::N_EV-1:0]    switch_event_report,
  output logic [ptp_pkg::TRACE_W-1:0] accepted_trace_value
);
  // quiet until the bench asks for traffic
  initial begin
    switch_event_report  = '0;
    accepted_trace_value = '0;
  end
  // one-cycle pulse per switch, no value carried
  task automatic pulse_event(input logic [N_EV-1:0] v);
    @(posedge ref_clk);
    switch_event_report <= v;
    @(posedge ref_clk);
    switch_event_report <= '0;
  endtask : pulse_event
  // received trace, may be one byte repeated
  task automatic set_trace(input logic [TRACE_W-1:0] t);
    @(posedge ref_clk);
    accepted_trace_value <= t;
  endtask : set_trace
endmodule : ptp_adapt_model

// File: dv/testbench.sv
// self-checking bench for the protection and trace provisioning bank
// assumes ptp_pkg, ptp_top and the adaptation side model
`timescale 1ns/1ns
module testbench;
  import ptp_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] v;
  } ptp_row_s;
  logic               ref_clk = 1'b0;
  logic               rst_n   = 1'b0;
  logic [AW-1:0]      addr    = '0;
  logic [DW-1:0]      wdata   = '0;
  logic               wr_stb  = 1'b0;
  logic               rd_stb  = 1'b0;
  logic [DW-1:0]      rdata;
  logic [N_EV-1:0]    switch_event_report;
  logic [TRACE_W-1:0] accepted_trace_value;
  logic               snc_operation_mode_sel, trl_operation_mode_sel;
  logic [1:0]         snc_subnet_prot_kind;
  logic [3:0]         snc_wait_restore_time, trl_wait_restore_time;
  logic [6:0]         snc_hold_off_delay, trl_hold_off_delay;
  logic [7:0]         snc_members, snc_roles, trl_members, trl_roles;
  logic [2:0]         lms_external_switch_cmd, snc_external_switch_cmd;
  logic [2:0]         trl_external_switch_cmd;
  logic [3:0]         ring_external_switch_cmd;
  logic [TRACE_W-1:0] sent_trace_value, expected_trace_value;
  logic               expected_trace_mode, mismatch_detect_off;
  logic               trace_mismatch_defect, irq;
  int                 bad_count = 0;
  int                 cmp_count = 0;
  logic [31:0]        rd_val;
  logic [31:0]        exp_cmd;
  ptp_row_s           rows [16];
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  ptp_top #(.N_MEMB(8)) DUT (
    .ref_clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .switch_event_report, .accepted_trace_value,
    .snc_operation_mode_sel, .snc_subnet_prot_kind,
    .snc_wait_restore_time, .snc_hold_off_delay, .snc_members,
    .snc_roles, .trl_operation_mode_sel, .trl_wait_restore_time,
    .trl_hold_off_delay, .trl_members, .trl_roles,
    .lms_external_switch_cmd, .ring_external_switch_cmd,
    .snc_external_switch_cmd, .trl_external_switch_cmd,
    .sent_trace_value, .expected_trace_value, .expected_trace_mode,
    .mismatch_detect_off, .trace_mismatch_defect, .irq);
  ptp_adapt_model u_af (.ref_clk, .rst_n, .switch_event_report,
    .accepted_trace_value);
  // compare and count
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one-cycle register write
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : bus_wr
  // one-cycle read, data taken in the following cycle
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd
  // output settings in the register layout, with members and roles packed above the config fields in bits 16 to 31
  function automatic logic [31:0] view(input logic [7:0] a);
    case (a)
      SNC_CFG, SNC_MEMB: view = {snc_roles, snc_members, 1'b0,
        snc_hold_off_delay, snc_wait_restore_time, 1'b0,
        snc_subnet_prot_kind, snc_operation_mode_sel};
      TRL_CFG, TRL_MEMB: view = {trl_roles, trl_members, 1'b0,
        trl_hold_off_delay, trl_wait_restore_time, 3'h0,
        trl_operation_mode_sel};
      CMD_REG: view = {17'h0, trl_external_switch_cmd, 1'b0,
        snc_external_switch_cmd, ring_external_switch_cmd, 1'b0,
        lms_external_switch_cmd};
      default: view = {30'h0, mismatch_detect_off, expected_trace_mode};
    endcase
  endfunction : view
  // settings after reset
  task automatic chk_defaults();
    check("snc cfg", view(SNC_CFG), 32'h0000_0050);
    check("trl cfg", view(TRL_CFG), 32'h0000_0050);
    check("commands", view(CMD_REG), 32'h0);
    check("trace ctrl", view(TRACE_CTRL), 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
  endtask : chk_defaults
  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask : end_test
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // run needs under two hundred cycles; cut a hang short
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  initial begin
    rows = '{'{SNC_CFG, 32'h0000_64c3, 32'h0000_64c3},
             '{SNC_CFG, 32'h0000_64c7, 32'h0000_64c3},
             '{SNC_CFG, 32'h0000_00d3, 32'h0000_64c3},
             '{SNC_CFG, 32'h0000_6503, 32'h0000_64c3},
             '{SNC_CFG, 32'h0000_0004, 32'h0000_0004},
             '{SNC_CFG, 32'h0000_0001, 32'h0000_0004},
             '{SNC_MEMB, 32'h0000_a5c3, 32'ha5c3_0004},
             '{SNC_CFG, 32'h8000_0000, 32'h0000_0050},
             '{TRL_CFG, 32'h0000_64c1, 32'h0000_64c1},
             '{TRL_CFG, 32'h0000_64d1, 32'h0000_64c1},
             '{TRL_MEMB, 32'h0000_0f01, 32'h0f01_64c1},
             '{TRL_CFG, 32'h0000_6541, 32'h0f01_64c1},
             '{TRL_CFG, 32'h8000_0000, 32'h0000_0050},
             '{TRACE_CTRL, 32'h1, 32'h1},
             '{TRACE_CTRL, 32'h2, 32'h2},
             '{TRACE_CTRL, 32'h0, 32'h0}};
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk_defaults();
    end_test("reset");
    foreach (rows[k]) begin
      bus_wr(rows[k].a, rows[k].d);
      #1;
      check("row", view(rows[k].a), rows[k].v);
    end
    end_test("table");
    // every linear code and ring codes 1 to 15; illegal codes leave their field alone
    exp_cmd = 32'h0;
    for (int i = 1; i < 16; i++) begin
      bus_wr(CMD_REG, {17'h0, i[2:0], 1'b0, i[2:0], i[3:0], 1'b0, i[2:0]});
      if (i[2:0] != LC_NONE)
        exp_cmd[2:0] = i[2:0];
      if (i[3:0] <= RC_ALL_SB_BAR)
        exp_cmd[7:4] = i[3:0];
      if (i[2:0] != LC_NONE && i[2:0] <= LC_TRIAL) begin
        exp_cmd[10:8]  = i[2:0];
        exp_cmd[14:12] = i[2:0];
      end
      #1;
      check("cmd", view(CMD_REG), exp_cmd);
    end
    bus_rd(CMD_REG, rd_val);
    check("cmd read", rd_val, exp_cmd);
    end_test("commands");
    // reset in mid-run restores every default
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk_defaults();
    @(posedge ref_clk);
    rst_n <= 1'b1;
    end_test("second reset");
    // trace words, least significant word first
    for (int i = 0; i < TRACE_WORDS; i++) begin
      bus_wr(TX_BASE + 8'(4 * i), 32'h1122_3340 + i);
      bus_wr(EXP_BASE + 8'(4 * i), 32'h0102_0300 + i);
    end
    #1;
    for (int i = 0; i < TRACE_WORDS; i++) begin
      check("tx", sent_trace_value[32*i +: 32], 32'h1122_3340 + i);
      check("ex", expected_trace_value[32*i+:32], 32'h0102_0300 + i);
    end
    u_af.set_trace({16{8'h5a}});
    repeat (3) @(posedge ref_clk);
    #1;
    check("defect on", {31'h0, trace_mismatch_defect}, 32'h1);
    bus_rd(ACC_BASE, rd_val);
    check("acc word0", rd_val, 32'h5a5a_5a5a);
    u_af.set_trace({16{8'h3c}});
    bus_rd(ACC_BASE + 8'h4, rd_val);
    check("acc snapshot", rd_val, 32'h5a5a_5a5a);
    bus_rd(STATUS_REG, rd_val);
    check("status", rd_val, 32'h0000_000a);
    bus_wr(TRACE_CTRL, 32'h2);
    repeat (2) @(posedge ref_clk);
    #1;
    check("defect off", {31'h0, trace_mismatch_defect}, 32'h0);
    bus_wr(TRACE_CTRL, 32'h0);
    for (int i = 0; i < TRACE_WORDS; i++)
      bus_wr(EXP_BASE + 8'(4 * i), 32'h3c3c_3c3c);
    repeat (2) @(posedge ref_clk);
    bus_rd(STATUS_REG, rd_val);
    check("status rep", rd_val, 32'h0000_0006);
    end_test("trace");
    // events: sticky, read clears, mask gates the level output
    bus_wr(IRQ_MASK, 32'h1);
    for (int i = 0; i < N_EV; i++) begin
      u_af.pulse_event(4'(1 << i));
      #1;
      check("irq", {31'h0, irq}, (i == 0) ? 32'h1 : 32'h0);
      bus_rd(IRQ_STAT, rd_val);
      check("event", rd_val, 32'(1 << i));
      check("irq clr", {31'h0, irq}, 32'h0);
      bus_rd(IRQ_STAT, rd_val);
      check("cleared", rd_val, 32'h0);
    end
    // event in the cycle of a status read survives the clear
    fork
      u_af.pulse_event(4'h2);
      bus_rd(IRQ_STAT, rd_val);
    join
    check("same cycle", rd_val, 32'h0);
    bus_rd(IRQ_STAT, rd_val);
    check("set wins", rd_val, 32'h2);
    bus_wr(8'h30, 32'hffff_ffff);
    bus_rd(8'h30, rd_val);
    check("unmapped", rd_val, 32'h0);
    end_test("events");
    finish_test();
  end
endmodule : testbench
